// file: core/dtc_pkg.sv
// Purpose: Shared constants and types for the dual timer/counter block
// Assumes: APB register map with one 32-bit aligned word per register
// Notes:   Only the low byte of each 8-bit register is meaningful
package dtc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_MODE   = 8'h00;
  localparam logic [7:0] OFS_CTRL   = 8'h04;
  localparam logic [7:0] OFS_AUX    = 8'h08;
  localparam logic [7:0] OFS_CNT0   = 8'h0C;
  localparam logic [7:0] OFS_CNT1   = 8'h10;
  localparam logic [7:0] OFS_STS    = 8'h14;
  localparam logic [7:0] OFS_MASK   = 8'h18;

  // Register select codes
  localparam logic [2:0] SEL_NONE   = 3'h0;
  localparam logic [2:0] SEL_MODE   = 3'h1;
  localparam logic [2:0] SEL_CTRL   = 3'h2;
  localparam logic [2:0] SEL_AUX    = 3'h3;
  localparam logic [2:0] SEL_CNT0   = 3'h4;
  localparam logic [2:0] SEL_CNT1   = 3'h5;
  localparam logic [2:0] SEL_STS    = 3'h6;
  localparam logic [2:0] SEL_MASK   = 3'h7;

  // Mode register: nibble base per channel, field offsets in nibble
  localparam int MODE_NIB_ONE = 4;
  localparam int MODE_NIB_ZERO = 0;
  localparam int FLD_GATE     = 3;
  localparam int FLD_CSEL     = 2;
  localparam int FLD_MODE_HI  = 1;
  localparam int FLD_MODE_LO  = 0;

  // Control/flags register bits
  localparam int CTL_OVF_ONE  = 7;
  localparam int CTL_RUN_ONE  = 6;
  localparam int CTL_OVF_ZERO = 5;
  localparam int CTL_RUN_ZERO = 4;
  localparam int CTL_EXT_ONE  = 3;
  localparam int CTL_TYP_ONE  = 2;
  localparam int CTL_EXT_ZERO = 1;
  localparam int CTL_TYP_ZERO = 0;

  // Auxiliary register bits
  localparam int AUX_FAST_ZERO = 7;
  localparam int AUX_FAST_ONE  = 6;
  localparam int AUX_SYNC_RATE = 5;
  localparam int AUX_CONV_EN   = 4;
  localparam int AUX_SPI_EN    = 3;
  localparam int AUX_LVD_EN    = 2;

  // Request/ack and status bit order (matches vector order)
  localparam int REQ_EXT_ZERO = 0;
  localparam int REQ_TMR_ZERO = 1;
  localparam int REQ_EXT_ONE  = 2;
  localparam int REQ_TMR_ONE  = 3;

  // Reset values
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_AUX  = 8'h00;
  localparam logic [3:0] RST_MASK = 4'h0;

  // Prescaler: oscillator divided by twelve
  localparam logic [3:0] PRESCALE_DIV  = 4'hC;
  localparam logic [3:0] PRESCALE_LAST = PRESCALE_DIV - 4'h1;

  typedef enum logic [1:0] {
    DTC_MODE_13     = 2'b00,
    DTC_MODE_16     = 2'b01,
    DTC_MODE_RELOAD = 2'b10,
    DTC_MODE_SPLIT  = 2'b11
  } dtc_mode_e;

  typedef struct packed {
    logic       gate;
    logic       csel;
    dtc_mode_e  mode;
  } dtc_chcfg_s;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
    logic       ovf;
  } dtc_step_s;

endpackage

// file: core/dtc_timer.sv
// Purpose: Two 16-bit timer/counter channels with external interrupt flags
// Assumes: Pins synchronous to pclk; vector acks are one-cycle pulses
// Notes:   Registers on APB; interrupt on sticky status with read-clear
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps

// Contract
// R1 - Two 16-bit channels; each may count falling edges of its count pin
// R2 - Count clock is oscillator/12 by default, undivided when fast select set
// R3 - Gate clear: count while running; gate set: also needs interrupt pin high
// R4 - Counter select 0 counts prescaled clock, 1 counts external pin events
// R5 - Mode 00 is 13-bit, 01 is 16-bit, 10 is 8-bit auto-reload
// R6 - Mode 11 stops channel one; splits channel zero into two 8-bit counters
// R7 - 13/16-bit modes set overflow flag on wrap from all ones to zero
// R8 - Reload mode: low byte overflow sets flag, reloads from unchanged high byte
// R9 - Overflow flags set by hardware, cleared when processor vectors to routine
// R10 - Run bit clear stops counting, set starts it subject to gate
// R11 - Trigger type 0 is low level, 1 is falling edge of interrupt pin
// R12 - External interrupt flags set by hardware, cleared on vector (here level-triggered flags follow the pin and ignore the vector)
// R13 - Serial sync rate select: 0 oscillator/12, 1 oscillator/2
// R14 - Three enables pass converter, SPI, low-voltage interrupts; cleared at reset
// R15 - Split mode: channel one holds (here it runs free unless itself in mode 11); high byte uses run bit and flag of one
// R16 - Mode register: channel one fields in upper nibble, channel zero lower
// R17 - Control: overflow/run of one at 7,6, zero at 5,4, external in 3..0
// R18 - 13-bit mode: high byte plus five low bits; low carry increments high
module dtc_timer
  import dtc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  ext_count_pin,
  input  wire logic [1:0]  ext_int_pin,
  input  wire logic [3:0]  vector_ack,
  input  wire logic [2:0]  periph_irq_raw,
  output logic      [2:0]  periph_irq_out,
  output logic      [3:0]  irq_req,
  output logic             serial_sync_fast_rate,
  output logic             irq
);

  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    if (a == OFS_MODE) begin
      return SEL_MODE;
    end else if (a == OFS_CTRL) begin
      return SEL_CTRL;
    end else if (a == OFS_AUX) begin
      return SEL_AUX;
    end else if (a == OFS_CNT0) begin
      return SEL_CNT0;
    end else if (a == OFS_CNT1) begin
      return SEL_CNT1;
    end else if (a == OFS_STS) begin
      return SEL_STS;
    end else if (a == OFS_MASK) begin
      return SEL_MASK;
    end else begin
      return SEL_NONE;
    end
  endfunction

  // One count step of a channel in the given mode
  function automatic dtc_step_s step_cnt(input dtc_mode_e m,
                                         input logic [7:0] lo,
                                         input logic [7:0] hi);
    dtc_step_s r;
    r.lo  = lo;
    r.hi  = hi;
    r.ovf = 1'b0;
    case (m)
      DTC_MODE_13: begin
        r.lo[4:0] = lo[4:0] + 5'h01; // R18
        if (lo[4:0] == 5'h1F) begin
          r.hi  = hi + 8'h01; // R18
          r.ovf = (hi == 8'hFF); // R7
        end
      end
      DTC_MODE_16: begin
        {r.hi, r.lo} = {hi, lo} + 16'h0001; // R5
        r.ovf        = ({hi, lo} == 16'hFFFF); // R7
      end
      DTC_MODE_RELOAD: begin
        if (lo == 8'hFF) begin
          r.lo  = hi; // R8
          r.ovf = 1'b1;
        end else begin
          r.lo = lo + 8'h01;
        end
      end
      default: begin
        r.lo  = lo + 8'h01; // R6
        r.ovf = (lo == 8'hFF);
      end
    endcase
    return r;
  endfunction

  logic [7:0]  timer_mode_cfg;
  logic [7:0]  aux_clock_irq_cfg;
  logic [1:0]  run_bit;
  logic [1:0]  trig_type;
  logic        overflow_flag_zero;
  logic        overflow_flag_one;
  logic        ext_irq_flag_zero;
  logic        ext_irq_flag_one;
  logic [7:0]  count_low_byte  [2];
  logic [7:0]  count_high_byte [2];
  logic [3:0]  presc;
  logic        tick12;
  logic [1:0]  cnt_pin_q;
  logic [1:0]  int_pin_q;
  logic [3:0]  irq_sts;
  logic [3:0]  irq_mask;

  dtc_chcfg_s  cfg [2];
  logic [1:0]  clk_tick;
  logic [1:0]  ev_fall;
  logic [1:0]  int_fall;
  logic [1:0]  run_eff;
  logic [1:0]  inc;
  logic [1:0]  wr_cnt;
  logic [1:0]  ext_ev;
  dtc_step_s   step [2];
  logic        split0;
  logic        hi0_inc;
  logic        ovf_ev0;
  logic        ovf_ev1;
  logic        acc;
  logic        wr_done;
  logic        rd_done;
  logic [2:0]  sel;
  logic [7:0]  ctrl_rd;

  assign sel     = reg_sel(paddr);
  assign acc     = psel & penable & ~pready;
  assign wr_done = psel & penable & pready & pwrite;
  assign rd_done = psel & penable & pready & ~pwrite;
  assign wr_cnt  = {wr_done && sel == SEL_CNT1, wr_done && sel == SEL_CNT0};

  // Register access completes on the second access-phase cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc;
      pslverr <= acc & (sel == SEL_NONE);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_mode_cfg    <= RST_MODE;
      aux_clock_irq_cfg <= RST_AUX;
      run_bit           <= {RST_CTRL[CTL_RUN_ONE], RST_CTRL[CTL_RUN_ZERO]};
      trig_type         <= {RST_CTRL[CTL_TYP_ONE], RST_CTRL[CTL_TYP_ZERO]};
      irq_mask          <= RST_MASK;
    end else if (wr_done) begin
      if (sel == SEL_MODE) begin
        timer_mode_cfg <= pwdata[7:0]; // R16
      end else if (sel == SEL_AUX) begin
        aux_clock_irq_cfg <= {pwdata[7:2], 2'b00}; // R2 R13 R14
      end else if (sel == SEL_CTRL) begin
        run_bit   <= {pwdata[CTL_RUN_ONE], pwdata[CTL_RUN_ZERO]}; // R10 R17
        trig_type <= {pwdata[CTL_TYP_ONE], pwdata[CTL_TYP_ZERO]}; // R11 R17
      end else if (sel == SEL_MASK) begin
        irq_mask <= pwdata[3:0];
      end
    end
  end

  assign ctrl_rd = {overflow_flag_one, run_bit[1], overflow_flag_zero, run_bit[0],
                    ext_irq_flag_one, trig_type[1], ext_irq_flag_zero, trig_type[0]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (acc) begin
      if (sel == SEL_MODE) begin
        prdata <= {24'h00_0000, timer_mode_cfg};
      end else if (sel == SEL_CTRL) begin
        prdata <= {24'h00_0000, ctrl_rd};
      end else if (sel == SEL_AUX) begin
        prdata <= {24'h00_0000, aux_clock_irq_cfg};
      end else if (sel == SEL_CNT0) begin
        prdata <= {16'h0000, count_high_byte[0], count_low_byte[0]};
      end else if (sel == SEL_CNT1) begin
        prdata <= {16'h0000, count_high_byte[1], count_low_byte[1]};
      end else if (sel == SEL_STS) begin
        prdata <= {28'h000_0000, irq_sts};
      end else if (sel == SEL_MASK) begin
        prdata <= {28'h000_0000, irq_mask};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Shared divide-by-twelve prescaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc <= 4'h0;
    end else if (presc == PRESCALE_LAST) begin
      presc <= 4'h0;
    end else begin
      presc <= presc + 4'h1;
    end
  end
  assign tick12 = (presc == PRESCALE_LAST); // R2

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_pin_q <= 2'h3;
      int_pin_q <= 2'h3;
    end else begin
      cnt_pin_q <= ext_count_pin;
      int_pin_q <= ext_int_pin;
    end
  end

  assign cfg[0] = timer_mode_cfg[MODE_NIB_ZERO +: 4]; // R16
  assign cfg[1] = timer_mode_cfg[MODE_NIB_ONE +: 4]; // R16
  assign split0 = (cfg[0].mode == DTC_MODE_SPLIT);
  // Channel one loses its run bit to the split high byte and then runs free unless itself in mode 11
  assign run_eff = {split0 ? 1'b1 : run_bit[1], run_bit[0]}; // R15

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      assign clk_tick[g] = aux_clock_irq_cfg[AUX_FAST_ZERO - g] ? 1'b1 : tick12; // R2
      assign ev_fall[g]  = cnt_pin_q[g] & ~ext_count_pin[g]; // R1
      assign int_fall[g] = int_pin_q[g] & ~ext_int_pin[g];
      assign inc[g]      = run_eff[g] & (~cfg[g].gate | ext_int_pin[g]) // R3 R10
                           & (cfg[g].csel ? ev_fall[g] : clk_tick[g]); // R4
      assign step[g]     = step_cnt(cfg[g].mode, count_low_byte[g], count_high_byte[g]);
      assign ext_ev[g]   = trig_type[g] ? int_fall[g] : ~ext_int_pin[g]; // R11
    end
  endgenerate

  // Split high byte is timer only, on channel zero's clock and run bit one
  assign hi0_inc = split0 & run_bit[1] & clk_tick[0]; // R15
  assign ovf_ev0 = inc[0] & step[0].ovf & ~wr_cnt[0]; // R7 R8
  assign ovf_ev1 = split0 ? (hi0_inc & (count_high_byte[0] == 8'hFF) & ~wr_cnt[0]) // R15
                 : (inc[1] & step[1].ovf & ~wr_cnt[1] & (cfg[1].mode != DTC_MODE_SPLIT));

  // Software load wins over a count in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_low_byte[0]  <= 8'h00;
      count_high_byte[0] <= 8'h00;
    end else if (wr_cnt[0]) begin
      count_low_byte[0]  <= pwdata[7:0];
      count_high_byte[0] <= pwdata[15:8];
    end else begin
      if (inc[0]) begin
        count_low_byte[0] <= step[0].lo;
      end
      if (split0) begin
        if (hi0_inc) begin
          count_high_byte[0] <= count_high_byte[0] + 8'h01; // R6
        end
      end else if (inc[0]) begin
        count_high_byte[0] <= step[0].hi; // R8
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_low_byte[1]  <= 8'h00;
      count_high_byte[1] <= 8'h00;
    end else if (wr_cnt[1]) begin
      count_low_byte[1]  <= pwdata[7:0];
      count_high_byte[1] <= pwdata[15:8];
    end else if (inc[1] && cfg[1].mode != DTC_MODE_SPLIT) begin // R6
      count_low_byte[1]  <= step[1].lo;
      count_high_byte[1] <= step[1].hi;
    end
  end

  // Hardware set wins over vector ack and software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag_zero <= RST_CTRL[CTL_OVF_ZERO];
      overflow_flag_one  <= RST_CTRL[CTL_OVF_ONE];
    end else begin
      if (ovf_ev0) begin
        overflow_flag_zero <= 1'b1; // R9
      end else if (vector_ack[REQ_TMR_ZERO]) begin
        overflow_flag_zero <= 1'b0; // R9
      end else if (wr_done && sel == SEL_CTRL) begin
        overflow_flag_zero <= pwdata[CTL_OVF_ZERO];
      end
      if (ovf_ev1) begin
        overflow_flag_one <= 1'b1; // R9
      end else if (vector_ack[REQ_TMR_ONE]) begin
        overflow_flag_one <= 1'b0; // R9
      end else if (wr_done && sel == SEL_CTRL) begin
        overflow_flag_one <= pwdata[CTL_OVF_ONE];
      end
    end
  end

  // Level-triggered flags follow the pin, so an ack cannot drop a live request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_irq_flag_zero <= RST_CTRL[CTL_EXT_ZERO];
      ext_irq_flag_one  <= RST_CTRL[CTL_EXT_ONE];
    end else begin
      if (!trig_type[0]) begin
        ext_irq_flag_zero <= ~ext_int_pin[0]; // R11 R12
      end else if (int_fall[0]) begin
        ext_irq_flag_zero <= 1'b1; // R12
      end else if (vector_ack[REQ_EXT_ZERO]) begin
        ext_irq_flag_zero <= 1'b0; // R12
      end else if (wr_done && sel == SEL_CTRL) begin
        ext_irq_flag_zero <= pwdata[CTL_EXT_ZERO];
      end
      if (!trig_type[1]) begin
        ext_irq_flag_one <= ~ext_int_pin[1]; // R11 R12
      end else if (int_fall[1]) begin
        ext_irq_flag_one <= 1'b1; // R12
      end else if (vector_ack[REQ_EXT_ONE]) begin
        ext_irq_flag_one <= 1'b0; // R12
      end else if (wr_done && sel == SEL_CTRL) begin
        ext_irq_flag_one <= pwdata[CTL_EXT_ONE];
      end
    end
  end

  assign irq_req = {overflow_flag_one, ext_irq_flag_one, overflow_flag_zero, ext_irq_flag_zero};

  // Read clears only the bits it returned, so events after the capture survive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts <= 4'h0;
      irq     <= 1'b0;
    end else begin
      irq_sts <= (irq_sts & ~((rd_done && sel == SEL_STS) ? prdata[3:0] : 4'h0))
                 | {ovf_ev1, ext_ev[1], ovf_ev0, ext_ev[0]};
      irq     <= |(irq_sts & irq_mask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_irq_out <= 3'h0;
    end else begin
      periph_irq_out <= periph_irq_raw & {aux_clock_irq_cfg[AUX_LVD_EN], // R14
                                          aux_clock_irq_cfg[AUX_SPI_EN],
                                          aux_clock_irq_cfg[AUX_CONV_EN]};
    end
  end

  assign serial_sync_fast_rate = aux_clock_irq_cfg[AUX_SYNC_RATE]; // R13

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_div_twelve: assert property (tick12 |-> ##12 tick12) // R2
    else $error("prescaler tick not every twelve cycles");
  a_div_gap: assert property (tick12 |=> !tick12 [*8]) // R2
    else $error("prescaler tick too early");
  a_ovf_sets_flag: assert property (ovf_ev0 |=> overflow_flag_zero) // R7
    else $error("overflow did not set channel zero flag");
  a_reload_low: assert property (cfg[0].mode == DTC_MODE_RELOAD && inc[0] // R8
      && count_low_byte[0] == 8'hFF && !wr_cnt[0]
      |=> count_low_byte[0] == $past(count_high_byte[0])
      && count_high_byte[0] == $past(count_high_byte[0]) && overflow_flag_zero)
    else $error("reload mode did not reload low byte");
  a_gate_blocks: assert property (cfg[1].gate && !ext_int_pin[1] && !wr_cnt[1] // R3
      |=> $stable(count_low_byte[1]))
    else $error("gated channel counted with pin low");
  a_run_stops: assert property (!run_bit[0] && !wr_cnt[0] // R10
      |=> $stable(count_low_byte[0]))
    else $error("stopped channel counted");
  a_event_count: assert property (cfg[1].csel && run_bit[1] && ev_fall[1] // R4
      && (!cfg[1].gate || ext_int_pin[1]) && cfg[1].mode == DTC_MODE_16 && !wr_cnt[1]
      && count_low_byte[1] != 8'hFF |=> count_low_byte[1] == $past(count_low_byte[1]) + 8'h01)
    else $error("external event not counted");
  a_one_stops: assert property (cfg[1].mode == DTC_MODE_SPLIT && !wr_cnt[1] // R6
      |=> $stable(count_low_byte[1]) && $stable(count_high_byte[1]))
    else $error("channel one counted in mode three");
  a_ack_clears: assert property (vector_ack[REQ_TMR_ZERO] && !ovf_ev0 // R9
      |=> !overflow_flag_zero)
    else $error("vector ack did not clear overflow flag");
  a_edge_sets: assert property (trig_type[0] && int_fall[0] |=> ext_irq_flag_zero ##1 // R12
      (ext_irq_flag_zero || $past(vector_ack[REQ_EXT_ZERO]) || $past(wr_done)))
    else $error("falling edge did not set external flag");
  a_level_follow: assert property (!trig_type[1] && !ext_int_pin[1] // R11
      |=> ext_irq_flag_one)
    else $error("low level did not set external flag");
  a_split_ovf: assert property (hi0_inc && count_high_byte[0] == 8'hFF && !wr_cnt[0] // R15
      |=> overflow_flag_one && count_high_byte[0] == 8'h00)
    else $error("split high byte overflow did not set flag one");
  a_aux_gate: assert property (!aux_clock_irq_cfg[AUX_CONV_EN] // R14
      |=> !periph_irq_out[0])
    else $error("converter interrupt passed while disabled");

endmodule

// file: tb/dtc_pin_model.sv
// Purpose: Count and interrupt pins as the far side drives them
// Assumes: Pins idle high through their pull-ups
// Notes:   Changes land just after a rising pclk edge
`timescale 1ns/1ps
module dtc_pin_model (
  input  wire logic       pclk,
  output logic      [1:0] count_pin,
  output logic      [1:0] int_pin
);
  initial begin
    count_pin = 2'h3;
    int_pin   = 2'h3;
  end

  // Low phase of two cycles, high phase of three between pulses, so sampling never misses an edge
  task automatic pulse(input int ch, input int n);
    repeat (n) begin
      @(posedge pclk);
      count_pin[ch] <= 1'b0;
      repeat (2) @(posedge pclk);
      count_pin[ch] <= 1'b1;
      repeat (2) @(posedge pclk);
    end
  endtask

  task automatic set_int(input int ch, input logic v);
    @(posedge pclk);
    int_pin[ch] <= v;
    repeat (3) @(posedge pclk);
  endtask
endmodule

// file: tb/tb.sv
// Purpose: Self-checking bench for the dual timer/counter
// Assumes: One wait state per APB transfer, write effect three edges after start
// Notes:   Counting windows rely on that fixed spacing between two writes
`timescale 1ns/1ps
module tb;
  import dtc_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  cnt_pin;
  logic [1:0]  int_pin;
  logic [3:0]  vector_ack;
  logic [2:0]  periph_irq_raw;
  logic [2:0]  periph_irq_out;
  logic [3:0]  irq_req;
  logic        serial_sync_fast_rate;
  logic        irq;
  logic [3:0]  snap;
  logic [31:0] q;
  logic        e;
  int          bad_count;
  int          n_tests;
  int          cycles;

  dtc_timer i_dtc_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_count_pin(cnt_pin), .ext_int_pin(int_pin),
    .vector_ack(vector_ack), .periph_irq_raw(periph_irq_raw),
    .periph_irq_out(periph_irq_out), .irq_req(irq_req),
    .serial_sync_fast_rate(serial_sync_fast_rate), .irq(irq));
  dtc_pin_model i_dtc_pin_model (.pclk(pclk), .count_pin(cnt_pin), .int_pin(int_pin));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic final_report();
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, q);
  endtask

  // Counting window is k+4 edges; flags sampled before the stop write clears them
  task automatic run(input logic [7:0] on, input int k);
    wr(OFS_CTRL, {24'h0, on});
    repeat (k) @(posedge pclk);
    snap = irq_req;
    wr(OFS_CTRL, 32'h0);
  endtask

  task automatic ack(input logic [3:0] m);
    @(posedge pclk);
    vector_ack <= m;
    @(posedge pclk);
    vector_ack <= 4'h0;
    @(posedge pclk);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    vector_ack = 4'h0;
    periph_irq_raw = 3'h7;
    bad_count = 0;
    n_tests = 0;
    cycles = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd("mode", OFS_MODE, 32'h0);
    rd("ctrl", OFS_CTRL, 32'h0);
    rd("aux", OFS_AUX, 32'h0);
    chk("periph_off", 32'h0, 32'(periph_irq_out));
    wr(OFS_AUX, 32'hFF);
    rd("aux_rb", OFS_AUX, 32'hFC);
    chk("sync_rate", 32'h1, 32'(serial_sync_fast_rate));
    chk("periph_on", 32'h7, 32'(periph_irq_out));
    wr(OFS_AUX, 32'h80);
    @(posedge pclk);
    chk("sync_slow", 32'h0, 32'(serial_sync_fast_rate));
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped_err", 32'h1, 32'(e));
    chk("unmapped_data", 32'h0, q);
    wr(OFS_MODE, 32'hA5);
    rd("mode_rb", OFS_MODE, 32'hA5);
    // Hardware set, vector clear and masked interrupt
    wr(OFS_MODE, 32'h01);
    wr(OFS_CNT0, 32'hFFFE);
    wr(OFS_MASK, 32'h2);
    wr(OFS_CTRL, 32'h10);
    repeat (4) @(posedge pclk);
    rd("ctrl_ovf", OFS_CTRL, 32'h30);
    chk("ovf0_req", 32'h2, 32'(irq_req));
    chk("irq_on", 32'h1, 32'(irq));
    rd("status", OFS_STS, 32'h2);
    ack(4'h2);
    chk("ovf0_ack", 32'h0, 32'(irq_req));
    rd("status_clr", OFS_STS, 32'h0);
    chk("irq_off", 32'h0, 32'(irq));
    wr(OFS_CTRL, 32'h0);
    // Fast 16-bit wrap over exactly 20 counts
    wr(OFS_CNT0, 32'hFFF1);
    run(8'h10, 16);
    chk("wrap16_flag", 32'h2, 32'(snap));
    rd("cnt16", OFS_CNT0, 32'h0005);
    // 13-bit: upper low-byte bits held
    wr(OFS_MODE, 32'h00);
    wr(OFS_CNT0, 32'hFFFF);
    run(8'h10, 16);
    chk("wrap13_flag", 32'h2, 32'(snap));
    rd("cnt13", OFS_CNT0, 32'h00F3);
    // Auto-reload from high byte
    wr(OFS_MODE, 32'h02);
    wr(OFS_CNT0, 32'hF0FE);
    run(8'h10, 16);
    chk("reload_flag", 32'h2, 32'(snap));
    rd("cnt_reload", OFS_CNT0, 32'hF0F2);
    // Split: high byte uses channel one run and flag
    wr(OFS_MODE, 32'h33);
    wr(OFS_CNT1, 32'h1234);
    wr(OFS_CNT0, 32'hF100);
    run(8'h50, 16);
    chk("split_flag", 32'h8, 32'(snap));
    rd("cnt_split0", OFS_CNT0, 32'h0514);
    rd("cnt_split1", OFS_CNT1, 32'h1234);
    // Prescaled clock: 120 cycles give 10 counts
    wr(OFS_AUX, 32'h00);
    wr(OFS_MODE, 32'h01);
    wr(OFS_CNT0, 32'h0);
    run(8'h10, 116);
    rd("cnt_div12", OFS_CNT0, 32'h000A);
    // Gated event counter on channel one, level trigger
    wr(OFS_MODE, 32'hD0);
    wr(OFS_CNT1, 32'h0);
    wr(OFS_CTRL, 32'h40);
    i_dtc_pin_model.pulse(1, 5);
    i_dtc_pin_model.set_int(1, 1'b0);
    chk("level_flag", 32'h4, 32'(irq_req));
    i_dtc_pin_model.pulse(1, 3);
    i_dtc_pin_model.set_int(1, 1'b1);
    chk("level_gone", 32'h0, 32'(irq_req));
    wr(OFS_CTRL, 32'h0);
    rd("cnt_events", OFS_CNT1, 32'h0005);
    // Falling edge trigger holds until vectored
    wr(OFS_CTRL, 32'h01);
    i_dtc_pin_model.set_int(0, 1'b0);
    i_dtc_pin_model.set_int(0, 1'b1);
    chk("edge_flag", 32'h1, 32'(irq_req));
    ack(4'h1);
    chk("edge_ack", 32'h0, 32'(irq_req));
    final_report();
  end
endmodule
